/* qbx_defs.vh */
`ifndef QBX_DEFS_VH
`define QBX_DEFS_VH
// system clock rate and bus timing
`define QBX_CLK_MHZ 250
// one quarter of the bus clock period, in ns; four quarters give 10 us (100 kHz)
`define QBX_QTR_NS 2500
// least time, rounded up to whole cycles
`define QBX_QTR_CYC ((`QBX_QTR_NS * `QBX_CLK_MHZ + 999) / 1000)
// address byte layout
`define QBX_ADDR_HI 4'h7
`define QBX_ADDR_HI_POS 4
`define QBX_STRAP_POS 1
`define QBX_RW_POS 0
// last bit index of a byte, the acknowledge slot
`define QBX_ACK_BIT 4'h8
// reset values
`define QBX_PIN_IDLE 1'b1
`define QBX_STRAP_RST 3'h0
`define QBX_DATA_RST 8'h00
`endif

/* qbx_sync.v */
`timescale 1ns/100ps
`include "qbx_defs.vh"
module qbx_sync
(
  input wire clock,
  input wire rst_n,
  input wire [1:0] pin_in,
  output wire [1:0] pin_out
);
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg filt_reg;
      // SDA and alert_n both idle high, so the stages reset high
      always @(posedge clock or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_reg <= `QBX_PIN_IDLE;
          s2_reg <= `QBX_PIN_IDLE;
          s3_reg <= `QBX_PIN_IDLE;
          filt_reg <= `QBX_PIN_IDLE;
        end
        else
        begin
          s1_reg <= pin_in[i];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // a change counts only once two later stages agree
          if (s2_reg == s3_reg)
            filt_reg <= s3_reg;
        end
      end
      assign pin_out[i] = filt_reg;
    end
  endgenerate
endmodule // qbx_sync

/* qbx_host.v */
// What this block does
// - caller writes a pin high before using it as an input; the block sends cmd_wdata unchanged.
// - host starts a transfer with SDA falling while SCL high.
// - host sends address byte MSB first, direction bit last.
// - strap inputs stay constant from start until stop.
// - host ends a transfer with SDA rising while SCL high.
`timescale 1ns/100ps
`include "qbx_defs.vh"
module qbx_host
#(
  // cycles per quarter bus period; the default keeps 100 kHz, a smaller value only shortens runs
  parameter QTR_CYC = `QBX_QTR_CYC
)
(
  input wire clock,
  input wire rst_n,
  input wire cmd_valid,
  input wire cmd_rw,
  input wire [2:0] cmd_straps,
  input wire [7:0] cmd_wdata,
  output reg cmd_ready_reg,
  output reg done_reg,
  output reg nack_reg,
  output reg [7:0] rdata_reg,
  output reg alert_reg,
  output reg [2:0] slave_addr_straps,
  output reg scl_o_reg,
  output reg scl_oe_reg,
  input wire sda_i,
  output reg sda_o_reg,
  output reg sda_oe_reg,
  input wire alert_n
);
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_START = 4'h2;
  localparam [3:0] ST_BYTE = 4'h4;
  localparam [3:0] ST_STOP = 4'h8;
  // the divider is 10 bits wide, so a quarter may not exceed 1024 cycles
  localparam [31:0] QTR_LAST_W = QTR_CYC - 1;
  localparam [9:0] QTR_LAST = QTR_LAST_W[9:0];

  wire [1:0] sync_out;
  wire sda_s;
  wire alert_n_s;
  reg [3:0] state_reg;
  reg [9:0] div_reg;
  reg tick_reg;
  reg [1:0] phase_reg;
  reg [3:0] bit_reg;
  reg byte_idx_reg;
  reg rw_reg;
  reg [7:0] wdata_reg;
  reg [7:0] shift_reg;

  qbx_sync u_sync
  (
    .clock(clock),
    .rst_n(rst_n),
    .pin_in({alert_n, sda_i}),
    .pin_out(sync_out)
  );
  assign sda_s = sync_out[0];
  assign alert_n_s = sync_out[1];

  // quarter-period enable; runs only while a transfer is in flight
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_reg <= 10'h000;
      tick_reg <= 1'b0;
    end
    else if (state_reg == ST_IDLE || div_reg == QTR_LAST)
    begin
      div_reg <= 10'h000;
      tick_reg <= (state_reg != ST_IDLE);
    end
    else
    begin
      div_reg <= div_reg + 10'h001;
      tick_reg <= 1'b0;
    end
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      phase_reg <= 2'h0;
      bit_reg <= 4'h0;
      byte_idx_reg <= 1'b0;
      rw_reg <= 1'b0;
      wdata_reg <= `QBX_DATA_RST;
      shift_reg <= `QBX_DATA_RST;
      cmd_ready_reg <= 1'b0;
      done_reg <= 1'b0;
      nack_reg <= 1'b0;
      rdata_reg <= `QBX_DATA_RST;
      alert_reg <= 1'b0;
      slave_addr_straps <= `QBX_STRAP_RST;
      scl_o_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_o_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      // alert is the device's level; the host only mirrors it
      alert_reg <= ~alert_n_s;
      if (tick_reg)
        phase_reg <= phase_reg + 2'h1;
      case (state_reg)
        ST_IDLE:
        begin
          cmd_ready_reg <= 1'b1;
          scl_oe_reg <= 1'b0;
          sda_oe_reg <= 1'b0;
          phase_reg <= 2'h0;
          if (cmd_valid && cmd_ready_reg)
          begin
            // straps only move here, so they hold from start to stop
            slave_addr_straps <= cmd_straps;
            rw_reg <= cmd_rw;
            // pins meant as inputs must arrive here as ones; the caller owns that choice
            wdata_reg <= cmd_wdata;
            cmd_ready_reg <= 1'b0;
            nack_reg <= 1'b0;
            state_reg <= ST_START;
          end
        end
        ST_START:
        begin
          if (tick_reg && phase_reg == 2'h1)
            sda_oe_reg <= 1'b1;
          if (tick_reg && phase_reg == 2'h3)
          begin
            scl_oe_reg <= 1'b1;
            // address byte: fixed high nibble, straps, direction last
            shift_reg <= {`QBX_ADDR_HI, slave_addr_straps, rw_reg};
            bit_reg <= 4'h0;
            byte_idx_reg <= 1'b0;
            state_reg <= ST_BYTE;
          end
        end
        ST_BYTE:
        begin
          if (tick_reg)
          begin
            case (phase_reg)
              2'h0:
              begin
                if (bit_reg == `QBX_ACK_BIT)
                  sda_oe_reg <= 1'b0;
                else if (byte_idx_reg && rw_reg)
                  sda_oe_reg <= 1'b0;
                else
                  sda_oe_reg <= ~shift_reg[7];
              end
              2'h1:
                scl_oe_reg <= 1'b0;
              2'h2:
              begin
                if (bit_reg == `QBX_ACK_BIT)
                begin
                  if (!byte_idx_reg && sda_s)
                    nack_reg <= 1'b1;
                  else if (byte_idx_reg && !rw_reg && sda_s)
                    nack_reg <= 1'b1;
                end
                else
                  shift_reg <= {shift_reg[6:0], sda_s};
              end
              default:
              begin
                scl_oe_reg <= 1'b1;
                if (bit_reg == `QBX_ACK_BIT)
                begin
                  bit_reg <= 4'h0;
                  if (byte_idx_reg && rw_reg)
                    rdata_reg <= shift_reg;
                  // one data byte per transfer; more would be ignored anyway
                  if (byte_idx_reg || nack_reg)
                    state_reg <= ST_STOP;
                  else
                  begin
                    byte_idx_reg <= 1'b1;
                    shift_reg <= rw_reg ? 8'hFF : wdata_reg;
                  end
                end
                else
                  bit_reg <= bit_reg + 4'h1;
              end
            endcase
          end
        end
        ST_STOP:
        begin
          if (tick_reg)
          begin
            case (phase_reg)
              2'h0:
                sda_oe_reg <= 1'b1;
              2'h1:
                scl_oe_reg <= 1'b0;
              2'h3:
              begin
                sda_oe_reg <= 1'b0;
                done_reg <= 1'b1;
                state_reg <= ST_IDLE;
              end
              default:
                sda_oe_reg <= 1'b1;
            endcase
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule // qbx_host

/* qbx_host_sva.sv */
`timescale 1ns/100ps
module qbx_host_sva
(
  input wire clock,
  input wire rst_n,
  input wire cmd_valid,
  input wire [2:0] cmd_straps,
  input wire cmd_ready_reg,
  input wire done_reg,
  input wire nack_reg,
  input wire alert_reg,
  input wire [2:0] slave_addr_straps,
  input wire scl_o_reg,
  input wire scl_oe_reg,
  input wire sda_o_reg,
  input wire sda_oe_reg,
  input wire alert_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire take = cmd_valid && cmd_ready_reg;
  chk_open_drain: assert property (!scl_o_reg && !sda_o_reg) else $error("line driven high");
  chk_take_busy: assert property (take |=> !cmd_ready_reg) else $error("ready after take");
  chk_straps_take: assert property (take |=> slave_addr_straps == $past(cmd_straps)) else $error("straps");
  chk_straps_hold: assert property (!cmd_ready_reg && !$past(cmd_ready_reg) |-> $stable(slave_addr_straps))
    else $error("straps moved");
  chk_idle_free: assert property (cmd_ready_reg |-> !scl_oe_reg && !sda_oe_reg) else $error("bus held");
  chk_done_pulse: assert property (done_reg |=> !done_reg && cmd_ready_reg) else $error("done shape");
  chk_stop_done: assert property ($fell(sda_oe_reg) && !scl_oe_reg |-> ##[0:3] done_reg) else $error("stop");
  chk_start_busy: assert property ($rose(sda_oe_reg) && !scl_oe_reg |-> !cmd_ready_reg) else $error("start");
  chk_nack_clr: assert property (take |-> ##[1:2] !nack_reg) else $error("nack kept");
  chk_alert_set: assert property (!alert_n [*8] |=> alert_reg) else $error("alert missed");
  chk_alert_clr: assert property (alert_n [*8] |=> !alert_reg) else $error("alert stuck");
  cov_ack: cover property (done_reg && !nack_reg);
  cov_nack: cover property (done_reg && nack_reg);
  cov_alert: cover property ($rose(alert_reg));
endmodule // qbx_host_sva
bind qbx_host qbx_host_sva u_sva(.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_straps(cmd_straps),
  .cmd_ready_reg(cmd_ready_reg), .done_reg(done_reg), .nack_reg(nack_reg), .alert_reg(alert_reg),
  .slave_addr_straps(slave_addr_straps), .scl_o_reg(scl_o_reg), .scl_oe_reg(scl_oe_reg), .sda_o_reg(sda_o_reg),
  .sda_oe_reg(sda_oe_reg), .alert_n(alert_n));

/* qbx_dev.sv */
`timescale 1ns/100ps
module qbx_dev
(
  input wire scl,
  input wire sda,
  input wire [2:0] straps,
  input wire [7:0] ext_in,
  output reg sda_low,
  output wire alert_n,
  output wire [7:0] port_pins
);
  reg [7:0] latch_reg = 8'hFF;
  reg [7:0] ref_reg = 8'hFF;
  reg [7:0] sh, rd;
  reg [3:0] cnt;
  reg [1:0] nbyte;
  reg act = 1'b0, sel = 1'b0, rw = 1'b0;
  initial sda_low = 1'b0;
  // weak high only, so the outside can pull any pin low
  assign port_pins = latch_reg & ext_in;
  // comparing with the cleared value also clears on return to old levels
  // zero delay, well inside the allowed alert set and release times
  assign alert_n = (port_pins == ref_reg);
  always @(negedge sda) if (scl) begin act = 1; cnt = 4'hF; nbyte = 0; sel = 0; end
  always @(posedge sda) if (scl) act = 0;
  always @(negedge scl) if (act)
  begin
    sda_low = 0;
    if (cnt == 8) begin cnt = 0; nbyte = nbyte + 1; end else cnt = cnt + 1;
    if (cnt == 8 && nbyte == 0)
    begin
      sel = (sh[7:1] == {4'h7, straps});
      rw = sh[0];
      sda_low = sel;
    end
    else if (cnt == 8) sda_low = sel && !rw && nbyte == 1;
    else if (sel && rw && nbyte == 1) sda_low = !rd[7 - cnt];
  end
  always @(posedge scl) if (act)
  begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else if (sel && rw && nbyte == 0) begin rd = port_pins; ref_reg = port_pins; end
    else if (sel && !rw && nbyte == 1) begin latch_reg = sh; ref_reg = sh & ext_in; end
  end
endmodule // qbx_dev

/* qbx_host_tb_top.sv */
`timescale 1ns/100ps
module qbx_host_tb_top;
  reg clock = 0, rst_n = 0, cmd_valid = 0, cmd_rw = 0;
  reg [2:0] cmd_straps = 0, mis = 0;
  reg [7:0] cmd_wdata = 0, ext_in = 8'hFF, w, p;
  wire cmd_ready_reg, done_reg, nack_reg, alert_reg, scl_o, scl_oe, sda_o, sda_oe, sda_low, alert_n;
  wire [7:0] rdata_reg, port_pins;
  wire [2:0] straps;
  wire sda = !(sda_oe || sda_low);
  integer error_cnt = 0, samples_checked = 0, cyc = 0, k, b;
  // a 160 ns quarter keeps the run short; the bus sequence does not depend on the rate
  qbx_host #(.QTR_CYC(40)) u_dut(.clock(clock), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_rw(cmd_rw),
    .cmd_straps(cmd_straps), .cmd_wdata(cmd_wdata), .cmd_ready_reg(cmd_ready_reg), .done_reg(done_reg),
    .nack_reg(nack_reg),
    .rdata_reg(rdata_reg), .alert_reg(alert_reg), .slave_addr_straps(straps), .scl_o_reg(scl_o),
    .scl_oe_reg(scl_oe), .sda_i(sda), .sda_o_reg(sda_o), .sda_oe_reg(sda_oe), .alert_n(alert_n));
  qbx_dev u_dev(.scl(!scl_oe), .sda(sda), .straps(straps ^ mis), .ext_in(ext_in), .sda_low(sda_low),
    .alert_n(alert_n), .port_pins(port_pins));
  initial forever #2 clock = !clock;
  task cmp(input string nm, input [7:0] exp, input [7:0] got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp) begin error_cnt = error_cnt + 1; $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end
  end
  endtask
  task cmp_flag(input string nm, input exp, input got);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp) begin error_cnt = error_cnt + 1; $display("CHECK FAILED %s exp %b got %b", nm, exp, got); end
  end
  endtask
  // a pin shows its latch where the outside leaves it high, else the outside level
  function [7:0] exp_port(input [7:0] latch, input [7:0] ext);
    exp_port = latch & ext;
  endfunction
  task give_verdict;
  begin
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  // three transfers at the short quarter need under 9k cycles
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000) begin error_cnt = error_cnt + 1; give_verdict; end
  end
  task xfer(input rw, input [2:0] s, input [7:0] d);
  begin
    cmd_valid <= 1; cmd_rw <= rw; cmd_straps <= s; cmd_wdata <= d;
    @(posedge clock);
    while (cmd_ready_reg !== 1'b1) @(posedge clock);
    cmd_valid <= 0;
    // a lost stop is caught by the cycle ceiling, which ends in the verdict
    while (done_reg !== 1'b1) @(posedge clock);
  end
  endtask
  initial
  begin
    k = $urandom(32'hD172E8B0);
    repeat (20) @(posedge clock);
    rst_n <= 1;
    repeat (2) @(posedge clock);
    cmp("pins", 8'hFF, port_pins);
    b = $urandom % 8;
    // the pin later used as an input is written high first
    w = $urandom | (8'h01 << b);
    xfer(0, $urandom, w);
    cmp("pins", exp_port(w, 8'hFF), port_pins);
    cmp_flag("nack", 1'b0, nack_reg);
    cmp_flag("alert", 1'b0, alert_reg);
    p = exp_port(w, ~(8'h01 << b));
    ext_in <= ~(8'h01 << b);
    repeat (20) @(posedge clock);
    cmp_flag("alert", 1'b1, alert_reg);
    xfer(1, straps, $urandom);
    cmp("rdata", p, rdata_reg);
    cmp_flag("alert", 1'b0, alert_reg);
    ext_in <= 8'hFF;
    mis <= 3'h1;
    repeat (20) @(posedge clock);
    xfer(0, straps, ~w);
    cmp_flag("nack", 1'b1, nack_reg);
    cmp("pins", exp_port(w, 8'hFF), port_pins);
    cmp_flag("alert", 1'b1, alert_reg);
    ext_in <= ~(8'h01 << b);
    repeat (20) @(posedge clock);
    cmp_flag("alert", 1'b0, alert_reg);
    give_verdict;
  end
endmodule // qbx_host_tb_top
